/* src/image_window_readout_control.sv */
// Purpose: register file and window readout framing of the sensor
// Assumes: clk is the register clock, link_clk the pixel clock
// Notes:   settings cross by toggle handshake, levels by synchronisers
`include "readout_regs.svh"
`default_nettype none
// How it works
// - identification word is read only; writes to it are dropped.
// - readout starts at the eleven-bit first-row setting, default twelve.
// - height holds rows minus one, default 1199; host keeps it two or more.
// - width holds columns minus one, default 1599; host keeps it odd, >= 3.
// - each row gets row-fill blanking of the programmed pixel clocks.
// - frames are separated by the programmed number of blank rows.
// - with sync clear, pending settings take effect at the next frame start.
// - while sync is set, pending settings stay unapplied until it clears.
// - chip-enable word mirrors sync into bit one and enable into bit zero.
// - enable clear stops readout; enable set reads out normally.
// - enable returning high restarts at the first row in a new frame.
// - test mode sends test value, then inverted, alternating per column.
// - invert bit set drives pixel clock out as the inverse of link clock.
// - a register changes only after both of its bytes have arrived.
module image_window_readout_control #(
    parameter logic [15:0] IDENT_CODE = 16'h0a5c, // arbitrary value
    parameter logic [9:0]  TEST_VALUE = 10'h2aa
) (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   link_clk,
    input  wire logic                   scl_i,
    input  wire logic                   sda_i,
    output logic                        sda_o,
    output logic                        sda_oe,
    input  wire logic [9:0]             array_data,
    output logic [10:0]                 array_row,
    output logic [10:0]                 array_col,
    output readout_pkg::pixel_out_t     pixel,
    output logic                        pix_clk_out
);

    localparam readout_pkg::win_cfg_t CFG_RST = '{
        row_start: `RST_FIRST_ROW,
        col_start: `RST_FIRST_COL,
        height:    `RST_HEIGHT,
        width:     `RST_WIDTH,
        hblank:    `RST_ROW_FILL,
        vblank:    `RST_FRAME_GAP
    };

    readout_pkg::reg_write_t  wr;
    logic [7:0]               rd_addr;
    logic [15:0]              rd_data;
    readout_pkg::reg_state_t  r_q;
    readout_pkg::reg_state_t  r_d;
    readout_pkg::link_state_t l_q;
    readout_pkg::link_state_t l_d;

    serial_register_port u_port (
        .clk     (clk),
        .rstn    (rstn),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .sda_o   (sda_o),
        .sda_oe  (sda_oe),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .wr      (wr)
    );

    // read mux, unmapped indices read as zero
    always_comb begin
        rd_data = 16'h0000;
        unique case (rd_addr)
            `REG_IDENT:     rd_data = IDENT_CODE;
            `REG_FIRST_ROW: rd_data = {5'h00, r_q.regs.row_start};
            `REG_FIRST_COL: rd_data = {5'h00, r_q.regs.col_start};
            `REG_HEIGHT:    rd_data = {5'h00, r_q.regs.height};
            `REG_WIDTH:     rd_data = {5'h00, r_q.regs.width};
            `REG_ROW_FILL:  rd_data = {5'h00, r_q.regs.hblank};
            `REG_FRAME_GAP: rd_data = {5'h00, r_q.regs.vblank};
            `REG_OUT_CTRL: begin
                rd_data[`CTRL_SYNC_BIT] = r_q.sync;
                rd_data[`CTRL_EN_BIT] = r_q.en;
                rd_data[`CTRL_TEST_BIT] = r_q.test;
                rd_data[`CTRL_INV_BIT] = r_q.inv;
            end
            `REG_CHIP_EN: begin
                rd_data[`CHIP_EN_SYNC] = r_q.sync;
                rd_data[`CHIP_EN_EN] = r_q.en;
            end
            default: rd_data = 16'h0000;
        endcase
    end

    // register domain
    always_comb begin
        r_d = r_q;
        r_d.ack_s = {r_q.ack_s[1:0], l_q.ack};
        if (r_q.ack_s[1] == r_q.ack_s[2]) begin
            r_d.ack_f = r_q.ack_s[2];
        end
        // snapshot held still until the link side has taken it
        if (r_q.dirty && !r_q.sync && (r_q.req == r_q.ack_f)) begin
            r_d.xfer = r_q.regs;
            r_d.req = ~r_q.req;
            r_d.dirty = 1'b0;
        end
        if (wr.strobe) begin
            unique case (wr.addr)
                `REG_FIRST_ROW: begin
                    r_d.regs.row_start = wr.data[10:0];
                    r_d.dirty = 1'b1;
                end
                `REG_FIRST_COL: begin
                    r_d.regs.col_start = wr.data[10:0];
                    r_d.dirty = 1'b1;
                end
                `REG_HEIGHT: begin
                    r_d.regs.height = wr.data[10:0];
                    r_d.dirty = 1'b1;
                end
                `REG_WIDTH: begin
                    r_d.regs.width = wr.data[10:0];
                    r_d.dirty = 1'b1;
                end
                `REG_ROW_FILL: begin
                    r_d.regs.hblank = wr.data[10:0];
                    r_d.dirty = 1'b1;
                end
                `REG_FRAME_GAP: begin
                    r_d.regs.vblank = wr.data[10:0];
                    r_d.dirty = 1'b1;
                end
                `REG_OUT_CTRL: begin
                    r_d.sync = wr.data[`CTRL_SYNC_BIT];
                    r_d.en = wr.data[`CTRL_EN_BIT];
                    r_d.test = wr.data[`CTRL_TEST_BIT];
                    r_d.inv = wr.data[`CTRL_INV_BIT];
                end
                `REG_CHIP_EN: begin
                    r_d.sync = wr.data[`CHIP_EN_SYNC];
                    r_d.en = wr.data[`CHIP_EN_EN];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_q <= '{regs: CFG_RST, xfer: CFG_RST, en: `RST_ENABLE,
                     default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // link domain
    always_comb begin
        logic        apply;
        logic        active;
        logic [11:0] row_len;
        logic [11:0] frame_len;
        apply = 1'b0;
        active = 1'b0;
        row_len = {1'b0, l_q.live.width} + {1'b0, l_q.live.hblank};
        frame_len = {1'b0, l_q.live.height} + {1'b0, l_q.live.vblank};
        l_d = l_q;
        l_d.req_s = {l_q.req_s[1:0], r_q.req};
        l_d.lvl_s1 = {r_q.sync, r_q.inv, r_q.test, r_q.en};
        l_d.lvl_s2 = l_q.lvl_s1;
        l_d.lvl_s3 = l_q.lvl_s2;
        for (int i = 0; i < 4; i++) begin
            if (l_q.lvl_s2[i] == l_q.lvl_s3[i]) begin
                l_d.lvl_f[i] = l_q.lvl_s3[i];
            end
        end
        if (l_q.req_s[1] == l_q.req_s[2]) begin
            l_d.req_f = l_q.req_s[2];
        end
        unique case (l_q.st)
            readout_pkg::R_STOP: begin
                l_d.x = 12'h000;
                l_d.y = 12'h000;
                if (l_q.lvl_f[0]) begin
                    l_d.st = readout_pkg::R_RUN;
                    apply = 1'b1;
                end
            end
            readout_pkg::R_RUN: begin
                if (!l_q.lvl_f[0]) begin
                    l_d.st = readout_pkg::R_STOP;
                    l_d.x = 12'h000;
                    l_d.y = 12'h000;
                end else if (l_q.x >= row_len) begin
                    l_d.x = 12'h000;
                    if (l_q.y >= frame_len) begin
                        l_d.y = 12'h000;
                        apply = 1'b1;
                    end else begin
                        l_d.y = l_q.y + 12'h001;
                    end
                end else begin
                    l_d.x = l_q.x + 12'h001;
                end
            end
        endcase
        // frame boundary, unless sync holds the new settings back
        if (apply && l_q.pend && !l_q.lvl_f[3]) begin
            l_d.live = l_q.stage;
            l_d.pend = 1'b0;
        end
        // a fresh snapshot wins over the apply that clears pend
        if (l_d.req_f != l_q.req_f) begin
            l_d.stage = r_q.xfer;
            l_d.pend = 1'b1;
            l_d.ack = l_d.req_f;
        end
        active = (l_q.st == readout_pkg::R_RUN)
              && (l_q.y <= {1'b0, l_q.live.height})
              && (l_q.x <= {1'b0, l_q.live.width});
        l_d.px.line_valid = active;
        l_d.px.frame_valid = (l_q.st == readout_pkg::R_RUN)
                          && (l_q.y <= {1'b0, l_q.live.height});
        if (!active) begin
            l_d.px.data = 10'h000;
        end else if (l_q.lvl_f[1]) begin
            l_d.px.data = l_q.x[0] ? ~TEST_VALUE : TEST_VALUE;
        end else begin
            l_d.px.data = array_data;
        end
        l_d.arow = l_q.live.row_start + l_q.y[10:0];
        l_d.acol = l_q.live.col_start + l_q.x[10:0];
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            l_q <= '{stage: CFG_RST, live: CFG_RST,
                     st: readout_pkg::R_STOP, default: '0};
        end else begin
            l_q <= l_d;
        end
    end

    // clock mux stays glitch-prone only while the invert bit changes
    assign pix_clk_out = l_q.lvl_f[2] ? ~link_clk : link_clk;
    assign pixel = l_q.px;
    assign array_row = l_q.arow;
    assign array_col = l_q.acol;

endmodule
`default_nettype wire

/* src/readout_pkg.sv */
// Purpose: shared types of the readout control block
// Assumes: nothing
// Notes:   constants live in readout_regs.svh
`default_nettype none
package readout_pkg;

    typedef struct packed {
        logic [10:0] row_start;
        logic [10:0] col_start;
        logic [10:0] height;
        logic [10:0] width;
        logic [10:0] hblank;
        logic [10:0] vblank;
    } win_cfg_t;

    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_ADDR  = 5'b00010,
        S_REG   = 5'b00100,
        S_WDATA = 5'b01000,
        S_RDATA = 5'b10000
    } serial_state_t;

    typedef enum logic [1:0] {
        R_STOP = 2'b01,
        R_RUN  = 2'b10
    } readout_state_t;

    typedef struct packed {
        logic        strobe;
        logic [7:0]  addr;
        logic [15:0] data;
    } reg_write_t;

    typedef struct packed {
        logic [9:0] data;
        logic       line_valid;
        logic       frame_valid;
    } pixel_out_t;

    typedef struct packed {
        logic [2:0]    scl_s;
        logic [2:0]    sda_s;
        logic          scl_f;
        logic          sda_f;
        serial_state_t st;
        logic [3:0]    cnt;
        logic          ackd;
        logic          rw;
        logic [7:0]    sh;
        logic          byte_lo;
        logic [7:0]    hold;
        logic [7:0]    ptr;
        logic          oe;
        reg_write_t    wr;
    } serial_state_s_t;

    typedef struct packed {
        win_cfg_t   regs;
        logic       sync;
        logic       en;
        logic       test;
        logic       inv;
        logic       dirty;
        win_cfg_t   xfer;
        logic       req;
        logic [2:0] ack_s;
        logic       ack_f;
    } reg_state_t;

    typedef struct packed {
        logic [2:0]     req_s;
        logic           req_f;
        logic [3:0]     lvl_s1;
        logic [3:0]     lvl_s2;
        logic [3:0]     lvl_s3;
        logic [3:0]     lvl_f;
        win_cfg_t       stage;
        win_cfg_t       live;
        logic           pend;
        logic           ack;
        readout_state_t st;
        logic [11:0]    x;
        logic [11:0]    y;
        pixel_out_t     px;
        logic [10:0]    arow;
        logic [10:0]    acol;
    } link_state_t;

endpackage
`default_nettype wire

/* src/readout_regs.svh */
// Purpose: register offsets, field positions and reset values
// Assumes: 16-bit registers addressed by an 8-bit index
// Notes:   constants only, no logic
`ifndef READOUT_REGS_SVH
`define READOUT_REGS_SVH

`define REG_IDENT      8'h00
`define REG_FIRST_ROW  8'h01
`define REG_FIRST_COL  8'h02
`define REG_HEIGHT     8'h03
`define REG_WIDTH      8'h04
`define REG_ROW_FILL   8'h05
`define REG_FRAME_GAP  8'h06
`define REG_OUT_CTRL   8'h07
`define REG_CHIP_EN    8'hf1

`define RST_FIRST_ROW  11'h00c
`define RST_FIRST_COL  11'h018
`define RST_HEIGHT     11'h4af
`define RST_WIDTH      11'h63f
`define RST_ROW_FILL   11'h035
`define RST_FRAME_GAP  11'h019
`define RST_ENABLE     1'b1

`define CTRL_SYNC_BIT  0
`define CTRL_EN_BIT    1
`define CTRL_TEST_BIT  6
`define CTRL_INV_BIT   15
`define CHIP_EN_SYNC   1
`define CHIP_EN_EN     0

`define SERIAL_DEV_ADDR 7'h5d
`define SERIAL_ACK_CNT  4'h8

`endif

/* src/serial_register_port.sv */
// Purpose: two-wire serial slave giving 16-bit register access
// Assumes: scl and sda are asynchronous pins, sda is open drain
// Notes:   high byte first; pointer steps after each 16-bit word
`include "readout_regs.svh"
`default_nettype none
module serial_register_port (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    scl_i,
    input  wire logic                    sda_i,
    output logic                         sda_o,
    output logic                         sda_oe,
    output logic [7:0]                   rd_addr,
    input  wire logic [15:0]             rd_data,
    output readout_pkg::reg_write_t      wr
);

    readout_pkg::serial_state_s_t q;
    readout_pkg::serial_state_s_t n;

    always_comb begin
        logic       scl_rise;
        logic       scl_fall;
        logic       sda_rise;
        logic       sda_fall;
        logic [7:0] byte_out;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        sda_rise = 1'b0;
        sda_fall = 1'b0;
        byte_out = q.byte_lo ? rd_data[7:0] : rd_data[15:8];
        n = q;
        n.wr.strobe = 1'b0;
        n.scl_s = {q.scl_s[1:0], scl_i};
        n.sda_s = {q.sda_s[1:0], sda_i};
        // only the second and third flops decide
        if (q.scl_s[1] == q.scl_s[2]) begin
            n.scl_f = q.scl_s[2];
        end
        if (q.sda_s[1] == q.sda_s[2]) begin
            n.sda_f = q.sda_s[2];
        end
        scl_rise = n.scl_f & ~q.scl_f;
        scl_fall = ~n.scl_f & q.scl_f;
        sda_rise = n.sda_f & ~q.sda_f;
        sda_fall = ~n.sda_f & q.sda_f;
        if (q.scl_f && n.scl_f && sda_fall) begin
            n.st = readout_pkg::S_ADDR;
            n.cnt = 4'h0;
            n.ackd = 1'b0;
            n.oe = 1'b0;
            n.byte_lo = 1'b0;
        end else if (q.scl_f && n.scl_f && sda_rise) begin
            n.st = readout_pkg::S_IDLE;
            n.ackd = 1'b0;
            n.oe = 1'b0;
        end else if (q.st != readout_pkg::S_IDLE && scl_rise) begin
            if (q.cnt == `SERIAL_ACK_CNT) begin
                n.cnt = 4'h0;
                n.ackd = 1'b1;
                // master nack ends a read
                if (q.st == readout_pkg::S_RDATA && n.sda_f) begin
                    n.st = readout_pkg::S_IDLE;
                    n.ackd = 1'b0;
                end
            end else begin
                n.cnt = q.cnt + 4'h1;
                if (q.st != readout_pkg::S_RDATA) begin
                    n.sh = {q.sh[6:0], n.sda_f};
                end
            end
        end else if (q.st != readout_pkg::S_IDLE && scl_fall) begin
            if (q.ackd) begin
                n.ackd = 1'b0;
                n.oe = 1'b0;
                unique case (q.st)
                    readout_pkg::S_ADDR: begin
                        n.st = q.rw ? readout_pkg::S_RDATA : readout_pkg::S_REG;
                    end
                    readout_pkg::S_REG: begin
                        n.st = readout_pkg::S_WDATA;
                    end
                    readout_pkg::S_WDATA,
                    readout_pkg::S_RDATA,
                    readout_pkg::S_IDLE: begin
                    end
                endcase
                if (n.st == readout_pkg::S_RDATA) begin
                    n.sh = byte_out;
                    n.oe = ~byte_out[7];
                    n.byte_lo = ~q.byte_lo;
                    if (q.byte_lo) begin
                        n.ptr = q.ptr + 8'h01;
                    end
                end
            end else if (q.cnt == `SERIAL_ACK_CNT) begin
                unique case (q.st)
                    readout_pkg::S_ADDR: begin
                        if (q.sh[7:1] == `SERIAL_DEV_ADDR) begin
                            n.oe = 1'b1;
                            n.rw = q.sh[0];
                        end else begin
                            n.st = readout_pkg::S_IDLE;
                        end
                    end
                    readout_pkg::S_REG: begin
                        n.ptr = q.sh;
                        n.oe = 1'b1;
                        n.byte_lo = 1'b0;
                    end
                    readout_pkg::S_WDATA: begin
                        n.oe = 1'b1;
                        if (!q.byte_lo) begin
                            n.hold = q.sh;
                            n.byte_lo = 1'b1;
                        end else begin
                            n.wr.strobe = 1'b1;
                            n.wr.addr = q.ptr;
                            n.wr.data = {q.hold, q.sh};
                            n.ptr = q.ptr + 8'h01;
                            n.byte_lo = 1'b0;
                        end
                    end
                    readout_pkg::S_RDATA: begin
                        n.oe = 1'b0;
                    end
                    readout_pkg::S_IDLE: begin
                    end
                endcase
            end else if (q.st == readout_pkg::S_RDATA && q.cnt != 4'h0) begin
                n.sh = {q.sh[6:0], 1'b0};
                n.oe = ~q.sh[6];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
                   st: readout_pkg::S_IDLE, default: '0};
        end else begin
            q <= n;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = q.oe;
    assign rd_addr = q.ptr;
    assign wr = q.wr;

endmodule
`default_nettype wire

/* verification/host_link_model.sv */
// Purpose: serial master and pixel array source
// Assumes: sda has a pull-up; device only pulls it low
// Notes:   bus pins move only at falling clk edges
`default_nettype none
module host_link_model (
    input  wire logic        clk,
    input  wire logic        sda_oe,
    output var logic         scl,
    output logic             sda,
    input  wire logic [10:0] array_row,
    input  wire logic [10:0] array_col,
    output logic [9:0]       array_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv = 1'b1;
    // pull-up: a released line reads high
    assign sda = drv & ~sda_oe;
    assign array_data = {array_row[4:0], array_col[4:0]};
    initial scl = 1'b1;
    task automatic hp();
        repeat (8) @(negedge clk);
    endtask
    task automatic start();
        drv = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        drv = 1'b0;
        hp();
        scl = 1'b0;
    endtask
    task automatic stop();
        hp();
        drv = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        drv = 1'b1;
        hp();
    endtask
    task automatic bit_x(input logic b, output logic r);
        hp();
        drv = b;
        hp();
        scl = 1'b1;
        hp();
        r = sda;
        scl = 1'b0;
    endtask
    task automatic byte_x(input logic [7:0] b, input logic a,
                          output logic [7:0] r);
        logic k;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
        bit_x(a, k);
    endtask
    // nb of 1 stops after the high byte
    task automatic wr_reg(input logic [7:0] idx, input logic [15:0] d,
                          input int nb);
        logic [7:0] r;
        start();
        byte_x(8'hba, 1'b1, r);
        byte_x(idx, 1'b1, r);
        byte_x(d[15:8], 1'b1, r);
        if (nb > 1) byte_x(d[7:0], 1'b1, r);
        stop();
    endtask
    task automatic rd_reg(input logic [7:0] idx, output logic [15:0] d);
        logic [7:0] r;
        start();
        byte_x(8'hba, 1'b1, r);
        byte_x(idx, 1'b1, r);
        start();
        byte_x(8'hbb, 1'b1, r);
        byte_x(8'hff, 1'b0, d[15:8]);
        byte_x(8'hff, 1'b1, d[7:0]);
        stop();
    endtask
endmodule
`default_nettype wire

/* verification/image_window_readout_control_assertions.sv */
// Purpose: framing and serial pin checks
// Assumes: rstn resets both domains
// Notes:   hblank of zero trips p_col_step
`default_nettype none
module image_window_readout_checker (
    input wire logic                   clk,
    input wire logic                   rstn,
    input wire logic                   link_clk,
    input wire logic                   scl_i,
    input wire logic                   sda_o,
    input wire logic                   sda_oe,
    input wire logic [10:0]            array_row,
    input wire logic [10:0]            array_col,
    input wire readout_pkg::pixel_out_t pixel
);
    logic [10:0] row_last_q;
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) row_last_q <= 11'h000;
        else if (pixel.line_valid) row_last_q <= array_row;
    end
    sequence s_new_frame;
        $rose(pixel.frame_valid);
    endsequence
    sequence s_scl_high;
        scl_i [*5];
    endsequence
    property p_frame_open;
        @(posedge link_clk) disable iff (!rstn)
        s_new_frame |-> pixel.line_valid;
    endproperty
    a_frame_open: assert property (p_frame_open)
        else $error("frame without line");
    property p_lv_in_fv;
        @(posedge link_clk) disable iff (!rstn)
        pixel.line_valid |-> pixel.frame_valid;
    endproperty
    a_lv_in_fv: assert property (p_lv_in_fv)
        else $error("lv outside frame");
    property p_idle_zero;
        @(posedge link_clk) disable iff (!rstn)
        !pixel.line_valid |-> pixel.data == 10'h000;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("data outside line");
    property p_col_step;
        @(posedge link_clk) disable iff (!rstn)
        pixel.line_valid && $past(pixel.line_valid)
            |-> array_col == $past(array_col) + 11'h001;
    endproperty
    a_col_step: assert property (p_col_step)
        else $error("column skipped");
    property p_row_hold;
        @(posedge link_clk) disable iff (!rstn)
        pixel.line_valid && $past(pixel.line_valid) |-> $stable(array_row);
    endproperty
    a_row_hold: assert property (p_row_hold)
        else $error("row changed in line");
    property p_row_step;
        @(posedge link_clk) disable iff (!rstn)
        $rose(pixel.line_valid) && !$rose(pixel.frame_valid)
            |-> array_row == row_last_q + 11'h001;
    endproperty
    a_row_step: assert property (p_row_step)
        else $error("row skipped");
    property p_ack_scl_low;
        @(posedge clk) disable iff (!rstn)
        $rose(sda_oe) |-> !scl_i;
    endproperty
    a_ack_scl_low: assert property (p_ack_scl_low)
        else $error("ack at scl high");
    property p_oe_hold;
        @(posedge clk) disable iff (!rstn)
        s_scl_high |-> $stable(sda_oe);
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("oe moved at scl high");
    property p_sda_low;
        @(posedge clk) disable iff (!rstn)
        sda_oe |-> sda_o == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low)
        else $error("sda driven high");
endmodule
bind image_window_readout_control image_window_readout_checker
    image_window_readout_checker_inst (.clk(clk), .rstn(rstn),
    .link_clk(link_clk), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .array_row(array_row), .array_col(array_col), .pixel(pixel));
`default_nettype wire

/* verification/image_window_readout_control_tb.sv */
// Purpose: register access and framing tests of the readout block
// Assumes: window set while readout is stopped
// Notes:   restart applies the small window
`default_nettype none
module image_window_readout_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] ID = 16'h3c71; // arbitrary value
    localparam logic [9:0]  TV = 10'h2aa;
    logic clk, rstn, link_clk, scl, sda, sda_o, sda_oe, pix_clk_out, pf;
    logic [10:0] array_row, array_col;
    logic [9:0]  array_data, d1;
    readout_pkg::pixel_out_t pixel, p0;
    logic [15:0] rd;
    logic [15:0] rst_v [1:6] = '{16'h000c, 16'h0018, 16'h04af, 16'h063f,
                                 16'h0035, 16'h0019};
    logic [15:0] cfg [1:6] = '{16'h0005, 16'h000a, 16'h0003, 16'h0007,
                               16'h0004, 16'h0002};
    logic [10:0] row0, col0;
    int err_total, checked, lv, fh, per;
    image_window_readout_control #(.IDENT_CODE(ID), .TEST_VALUE(TV))
        image_window_readout_control_inst (.clk(clk), .rstn(rstn),
        .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .array_data(array_data), .array_row(array_row),
        .array_col(array_col), .pixel(pixel), .pix_clk_out(pix_clk_out));
    host_link_model host (.clk(clk), .sda_oe(sda_oe), .scl(scl),
        .sda(sda), .array_row(array_row), .array_col(array_col),
        .array_data(array_data));
    always #25 clk = ~clk;
    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end
    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [15:0] e);
        host.rd_reg(idx, rd);
        chk($sformatf("reg %h", idx), rd, e);
    endtask
    task automatic scan();
        pf = 1'b1;
        for (int n = 0; n < 4000; n++) begin
            if (pf === 1'b0 && pixel.frame_valid === 1'b1) break;
            pf = pixel.frame_valid;
            @(negedge link_clk);
        end
        {lv, fh, per} = '0;
        p0 = pixel;
        row0 = array_row;
        col0 = array_col;
        forever begin
            lv += int'(pixel.line_valid);
            fh += int'(pixel.frame_valid);
            per++;
            pf = pixel.frame_valid;
            @(negedge link_clk);
            if (per == 1) d1 = pixel.data;
            if ((pixel.frame_valid === 1'b1 && pf === 1'b0) || per > 4000)
                break;
        end
    endtask
    task automatic close_out();
        if (err_total == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #4000000;
        err_total++;
        close_out();
    end
    initial begin
        {clk, rstn, err_total, checked} = '0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        host.wr_reg(8'h00, 16'hffff, 2);
        rchk(8'h00, ID);
        for (int i = 1; i < 7; i++) rchk(8'(i), rst_v[i]);
        rchk(8'h07, 16'h0002);
        rchk(8'hf1, 16'h0001);
        rchk(8'h08, 16'h0000);
        host.wr_reg(8'h07, 16'h0000, 2);
        repeat (100) @(negedge link_clk);
        fh = 0;
        repeat (200) @(negedge link_clk) fh += int'(pixel.frame_valid !== 1'b0);
        chk("stopped frames", 16'(fh), 16'h0000);
        for (int i = 1; i < 7; i++) host.wr_reg(8'(i), cfg[i], 2);
        host.wr_reg(8'h01, 16'h0007, 1);
        rchk(8'h01, 16'h0005);
        host.wr_reg(8'h07, 16'h0002, 2);
        scan();
        chk("first row", 16'(row0), 16'h0005);
        chk("first col", 16'(col0), 16'h000a);
        chk("line cycles", 16'(lv), 16'h0020);
        chk("frame rows", 16'(fh), 16'h0030);
        chk("row fill", 16'(fh - lv), 16'h0010);
        chk("frame period", 16'(per), 16'h0048);
        #1;
        chk("pix clk", 16'(pix_clk_out), 16'(link_clk));
        host.wr_reg(8'h07, 16'h0003, 2);
        host.wr_reg(8'h04, 16'h0005, 2);
        rchk(8'hf1, 16'h0003);
        scan();
        chk("held width", 16'(lv), 16'h0020);
        host.wr_reg(8'h07, 16'hffff, 2);
        rchk(8'h07, 16'h8043);
        @(posedge link_clk);
        #20;
        chk("inv clk", 16'(pix_clk_out), 16'(!link_clk));
        host.wr_reg(8'h07, 16'h0042, 2);
        scan();
        scan();
        chk("new width", 16'(lv), 16'h0018);
        chk("new period", 16'(per), 16'h003c);
        chk("test even", 16'(p0.data), 16'(TV));
        chk("test odd", 16'(d1), {6'h00, ~TV});
        close_out();
    end
endmodule
`default_nettype wire
